// *** flash_program_suspend.sv ***
// serial flash command logic: config write, page program, write suspend/resume
// assumes host pins are asynchronous and sampled by clk_i; array writes drain via a fifo
// Behaviour
// R1 - C0h plus one byte loads drive/dummy
// R2 - reset gives drive 00b, dummy 00b
// R3 - four-wire mode: two nibbles, upper first
// R4 - write-enable sets latch; program needs latch
// R5 - host holds select: opcode, address, data
// R6 - data past page end wraps to start
// R7 - over 256 bytes keeps last 256
// R8 - under 256 bytes touches only those
// R9 - select rising off byte boundary cancels
// R10 - select rise starts timed cycle, busy set
// R11 - protected page program is not executed
// R12 - 32h needs pin-disable bit and latch
// R13 - quad program: same rules, data on four
// R14 - B0h suspends; ignored if suspended/chip erase
// R15 - chip erase invalid while suspended
// R16 - erase suspend sets flag, blocks commands
// R17 - program suspend sets flag, blocks commands
// R18 - ready within 20 us after suspend
// R19 - suspended erase region reads are unknown
// R20 - 30h resumes and clears suspend flag
// R21 - suspended time excluded from total run
// R22 - host spaces resume and next suspend
// R23 - busy on 05h/09h, suspend flags on 09h
// R24 - single-line bits sampled rising, msb first
`timescale 1ns/1ps

module stream_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_type;
  fifo_state_type r, nxt;
  logic push, pop;

  // depth must be a power of two so the pointers wrap on their own
  assign in_ready_o = r.cnt != (AW + 1)'(DEPTH);
  assign out_valid_o = r.cnt != '0;
  assign out_data_o = r.mem[r.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    nxt = r;
    if (push) begin
      nxt.mem[r.wp] = in_data_i;
      nxt.wp = r.wp + AW'(1);
    end
    if (pop) begin
      nxt.rp = r.rp + AW'(1);
    end
    nxt.cnt = r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end
endmodule : stream_fifo

module flash_program_suspend import flash_pkg::*; #(
  parameter int PROG_CYCLES = PROG_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int SUSPEND_CYCLES = SUSPEND_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // host pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  // mode and protection settings
  input wire logic four_wire_command_mode_i,
  input wire logic pin_function_disable_bit_i,
  input wire protect_type protect_i,
  // erase requests decoded elsewhere
  input wire logic erase_start_i,
  input wire logic erase_is_chip_i,
  // status
  output logic write_busy_flag_o,
  output logic write_enable_latch_o,
  output logic erase_suspended_flag_o,
  output logic program_suspended_flag_o,
  output logic [1:0] drive_strength_o,
  output logic [1:0] read_dummy_o,
  // array write stream
  output logic mem_wr_valid_o,
  output wr_type mem_wr_o,
  input wire logic mem_wr_ready_i
);
  typedef struct packed {
    pins_type s1;
    pins_type s2;
    logic sclk_d;
    logic cs_d;
    cmd_state_type st;
    logic [7:0] opc;
    logic [7:0] sh;
    logic [2:0] bitc;
    logic [8:0] nbytes;
    logic [23:0] addr;
    logic [7:0] stat_sh;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic write_enable_latch;
    op_type op;
    logic susp_e;
    logic susp_p;
    logic busy;
    logic [31:0] remain;
    logic [15:0] slat;
    logic [1:0] drive;
    logic [1:0] dummy;
    logic [PAGE_BYTES-1:0][7:0] pbuf;
    logic [PAGE_BYTES-1:0] pval;
    logic drain;
    logic [7:0] didx;
  } top_state_type;
  top_state_type r, nxt;

  logic sclk_rise, sclk_fall, cs_rise, quad_now, byte_done, suspended, busy_now;
  logic [7:0] shifted;
  logic [2:0] bitc_n;
  logic fifo_in_valid, fifo_in_ready, page_locked;
  wr_type fifo_in;

  // the first sync stage feeds only the second; edges come from the second and a third copy
  assign sclk_rise = r.s2.sclk && !r.sclk_d && !r.s2.cs_n;
  assign sclk_fall = !r.s2.sclk && r.sclk_d && !r.s2.cs_n;
  assign cs_rise = r.s2.cs_n && !r.cs_d;
  assign quad_now = four_wire_command_mode_i || (r.st == ST_DATA && r.opc == OPC_QPROG); // R3 R13
  assign shifted = quad_now ? {r.sh[3:0], r.s2.io} : {r.sh[6:0], r.s2.io[0]}; // R3 R24
  assign bitc_n = r.bitc + (quad_now ? 3'h4 : 3'h1);
  assign byte_done = sclk_rise && bitc_n == 3'h0;
  assign suspended = r.susp_e || r.susp_p;
  assign busy_now = (r.op != OP_NONE && !suspended) || r.slat != '0;
  assign fifo_in_valid = r.drain && r.pval[r.didx];
  assign fifo_in = '{addr: {r.addr[23:8], r.didx}, data: r.pbuf[r.didx]};

  // block protection: level n of 1 to 5 guards 2^(n-1) 64k blocks from top or bottom; levels 6 and 7 guard all 16
  function automatic logic prot_hit(input protect_type p, input logic [3:0] blk);
    logic [4:0] n;
    logic hit;
    n = (p.level == 3'h0) ? 5'h0 : (p.level >= 3'h5) ? 5'h10 : 5'(1 << (p.level - 3'h1));
    hit = p.top_bottom ? ({1'b0, blk} < n) : ({1'b0, blk} >= 5'(BLOCKS) - n);
    return hit ^ p.complement;
  endfunction : prot_hit
  assign page_locked = prot_hit(protect_i, r.addr[19:16]);

  // command decode, page buffer, timed operation and suspend control
  always_comb begin
    nxt = r;
    nxt.s1 = '{cs_n: cs_n_i, sclk: sclk_i, io: io_i};
    nxt.s2 = r.s1;
    nxt.sclk_d = r.s2.sclk;
    nxt.cs_d = r.s2.cs_n;
    nxt.busy = busy_now; // R10 R23
    if (sclk_rise) begin
      nxt.sh = shifted;
      nxt.bitc = bitc_n;
    end
    // status bytes go out on falling edges and repeat while select stays low
    if (sclk_fall && r.st == ST_STAT) begin
      if (four_wire_command_mode_i) begin
        nxt.io_out = r.stat_sh[7:4];
        nxt.io_oe = 4'hf;
        nxt.stat_sh = {r.stat_sh[3:0], r.stat_sh[7:4]};
      end else begin
        nxt.io_out = {2'h0, r.stat_sh[7], 1'b0};
        nxt.io_oe = 4'h2;
        nxt.stat_sh = {r.stat_sh[6:0], r.stat_sh[7]};
      end
    end
    if (byte_done) begin
      case (r.st)
        ST_OPC: begin
          nxt.opc = shifted;
          nxt.st = ST_SKIP;
          nxt.nbytes = '0;
          nxt.stat_sh = '0;
          case (shifted)
            OPC_WRITE_ENABLE_CMD: begin
              if (!busy_now) nxt.write_enable_latch = 1'b1; // R4 R16 R17
            end
            OPC_CFG: begin
              if (!busy_now) nxt.st = ST_CFG;
            end
            OPC_PROG: begin
              if (!busy_now && !suspended && r.write_enable_latch) begin
                nxt.st = ST_ADDR; // R4
                nxt.pval = '0; // a refused opcode keeps a running drain intact
              end
            end
            OPC_QPROG: begin
              if (!busy_now && !suspended && r.write_enable_latch && pin_function_disable_bit_i
                  && !four_wire_command_mode_i) begin
                nxt.st = ST_ADDR; // R12
                nxt.pval = '0;
              end
            end
            OPC_STATUS: begin
              nxt.st = ST_STAT; // R23
              nxt.stat_sh[STAT_BUSY_BIT] = busy_now;
              nxt.stat_sh[STAT_WEL_BIT] = r.write_enable_latch;
            end
            OPC_SUSP_STATUS: begin
              nxt.st = ST_STAT; // R23
              nxt.stat_sh[STAT_BUSY_BIT] = busy_now;
              nxt.stat_sh[SUSP_ERASE_BIT] = r.susp_e;
              nxt.stat_sh[SUSP_PROG_BIT] = r.susp_p;
            end
            default: nxt.st = ST_SKIP;
          endcase
        end
        ST_ADDR: begin
          nxt.addr = {r.addr[15:0], shifted};
          nxt.nbytes = r.nbytes + 9'h1;
          if (r.nbytes == 9'h2) begin
            nxt.st = ST_DATA;
            nxt.nbytes = '0;
          end
        end
        ST_DATA: begin
          // later bytes overwrite earlier ones at the same column
          nxt.pbuf[r.addr[7:0]] = shifted; // R7 R8
          nxt.pval[r.addr[7:0]] = 1'b1; // R8
          nxt.addr[7:0] = r.addr[7:0] + 8'h1; // R6
          if (r.nbytes != 9'(PAGE_BYTES)) nxt.nbytes = r.nbytes + 9'h1;
        end
        ST_CFG: begin
          nxt.sh = shifted;
          nxt.nbytes = r.nbytes + 9'h1;
        end
        default: nxt.st = r.st;
      endcase
    end
    // select rising ends every command; partial bytes cancel the action
    if (cs_rise) begin
      nxt.st = ST_OPC;
      nxt.bitc = '0;
      nxt.io_oe = '0;
      if (r.bitc == 3'h0) begin // R9
        if (r.st == ST_CFG && r.nbytes == 9'h1) begin
          nxt.drive = r.sh[CFG_DRIVE_LSB +: 2]; // R1
          nxt.dummy = r.sh[CFG_DUMMY_LSB +: 2]; // R1
        end
        if (r.st == ST_DATA && r.nbytes != '0) begin
          nxt.write_enable_latch = 1'b0; // R10
          if (!page_locked) begin // R11
            nxt.op = OP_PROG; // R10
            nxt.remain = 32'(PROG_CYCLES);
            nxt.drain = 1'b1;
            nxt.didx = '0;
          end
        end
        if (r.st == ST_SKIP && r.opc == OPC_SUSPEND && !suspended && r.slat == '0
            && (r.op == OP_PROG || r.op == OP_ERASE)) begin // R14
          nxt.susp_p = r.op == OP_PROG; // R17
          nxt.susp_e = r.op == OP_ERASE; // R16
          nxt.slat = 16'(SUSPEND_CYCLES); // R18
        end
        if (r.st == ST_SKIP && r.opc == OPC_RESUME && suspended && r.slat == '0) begin
          nxt.susp_e = 1'b0; // R20
          nxt.susp_p = 1'b0; // R20
        end
      end
    end
    // erase requests arrive ready decoded; chip erase is refused while suspended
    if (erase_start_i && !busy_now && !(erase_is_chip_i && suspended) // R15
        && !(r.op != OP_NONE)) begin
      nxt.op = erase_is_chip_i ? OP_CHIP : OP_ERASE;
      nxt.remain = 32'(ERASE_CYCLES);
      nxt.write_enable_latch = 1'b0;
    end
    if (r.slat != '0) nxt.slat = r.slat - 16'h1; // R18
    // the timer freezes while suspended, so total run time stays the uninterrupted one
    if (r.op != OP_NONE && !suspended) begin // R21
      if (r.remain != '0) begin
        nxt.remain = r.remain - 32'h1;
      end else if (!r.drain && !mem_wr_valid_o) begin
        nxt.op = OP_NONE; // R10 busy holds until the array took every byte
      end
    end
    // hand buffered bytes to the array; only written columns are sent
    if (r.drain && (!r.pval[r.didx] || fifo_in_ready)) begin // R8
      nxt.didx = r.didx + 8'h1;
      if (r.didx == 8'hff) nxt.drain = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
      r.s1 <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
      r.s2 <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
      r.cs_d <= 1'b1;
      r.drive <= DRIVE_RST; // R2
      r.dummy <= DUMMY_RST; // R2
    end else begin
      r <= nxt;
    end
  end

  // the fifo stalls the drain when the array stops taking writes
  stream_fifo #(.W($bits(wr_type)), .DEPTH(FIFO_DEPTH)) wr_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(fifo_in_valid),
    .in_data_i(fifo_in),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(mem_wr_valid_o),
    .out_data_o(mem_wr_o),
    .out_ready_i(mem_wr_ready_i)
  );

  // outputs straight from state flops; erase flag also marks suspended region data unknown
  assign io_o = r.io_out;
  assign io_oe_o = r.io_oe;
  assign write_busy_flag_o = r.busy;
  assign write_enable_latch_o = r.write_enable_latch;
  assign erase_suspended_flag_o = r.susp_e; // R19
  assign program_suspended_flag_o = r.susp_p;
  assign drive_strength_o = r.drive;
  assign read_dummy_o = r.dummy;

  wel_set_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R4
    byte_done && r.st == ST_OPC && shifted == OPC_WRITE_ENABLE_CMD && !busy_now |=> r.write_enable_latch)
    else $error("write enable not latched");
  prog_needs_wel_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R4
    r.st == ST_ADDR && $past(r.st) == ST_OPC |-> $past(r.write_enable_latch))
    else $error("program accepted without write enable");
  quad_gate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R12
    r.st == ST_ADDR && r.opc == OPC_QPROG && $past(r.st) == ST_OPC
    |-> $past(pin_function_disable_bit_i))
    else $error("quad program accepted with pins enabled");
  col_wrap_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R6
    byte_done && r.st == ST_DATA && r.addr[7:0] == 8'hff |=> r.addr[7:0] == 8'h00)
    else $error("column did not wrap to page start");
  prog_busy_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R10
    cs_rise && r.bitc == 3'h0 && r.st == ST_DATA && r.nbytes != '0 && !page_locked
    |=> r.op == OP_PROG ##1 write_busy_flag_o)
    else $error("program cycle did not raise busy");
  cut_cmd_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R9
    cs_rise && r.bitc != 3'h0 && r.op == OP_NONE && !erase_start_i |=> r.op == OP_NONE)
    else $error("partial byte started an operation");
  locked_page_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R11
    cs_rise && r.st == ST_DATA && page_locked && r.op == OP_NONE && !erase_start_i
    |=> r.op == OP_NONE && !r.drain)
    else $error("protected page programmed");
  susp_ignore_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R14
    cs_rise && r.opc == OPC_SUSPEND && r.st == ST_SKIP && (suspended || r.op == OP_CHIP)
    |=> r.susp_e == $past(r.susp_e) && r.susp_p == $past(r.susp_p))
    else $error("suspend not ignored");
  chip_block_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R15
    erase_start_i && erase_is_chip_i && suspended |=> r.op != OP_CHIP)
    else $error("chip erase ran while suspended");
  susp_latency_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R16 R17 R18
    $rose(r.susp_e || r.susp_p) |-> r.slat == 16'(SUSPEND_CYCLES) && r.busy)
    else $error("suspend latency not loaded");
  freeze_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R21
    suspended && r.op != OP_NONE |=> r.remain == $past(r.remain))
    else $error("timer ran while suspended");
  resume_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R20
    cs_rise && r.bitc == 3'h0 && r.st == ST_SKIP && r.opc == OPC_RESUME && suspended
    && r.slat == '0 |=> !erase_suspended_flag_o && !program_suspended_flag_o)
    else $error("resume left a suspend flag set");
  prog_seen_c: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    r.op == OP_PROG && mem_wr_valid_o);
  susp_seen_c: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(r.susp_p));
  cfg_seen_c: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    $changed(r.drive));
endmodule : flash_program_suspend

// *** flash_pkg.sv ***
// constants, states and carrier types for the serial flash program/suspend block
// assumes one 250 MHz core clock; host pins arrive unsynchronised
package flash_pkg;
  // core clock rate and documented times
  localparam int CLK_MHZ = 250;
  localparam int SUSPEND_US = 20;
  localparam int PROG_US = 500;
  localparam int ERASE_US = 40000;
  localparam int SUSPEND_CYC = SUSPEND_US * CLK_MHZ;
  localparam int PROG_CYC = PROG_US * CLK_MHZ;
  localparam int ERASE_CYC = ERASE_US * CLK_MHZ;
  // opcodes
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OPC_CFG = 8'hc0;
  localparam logic [7:0] OPC_PROG = 8'h02;
  localparam logic [7:0] OPC_QPROG = 8'h32;
  localparam logic [7:0] OPC_SUSPEND = 8'hb0;
  localparam logic [7:0] OPC_RESUME = 8'h30;
  localparam logic [7:0] OPC_STATUS = 8'h05;
  localparam logic [7:0] OPC_SUSP_STATUS = 8'h09;
  // reset values and field positions
  localparam logic [1:0] DRIVE_RST = 2'h0;
  localparam logic [1:0] DUMMY_RST = 2'h0;
  localparam int CFG_DRIVE_LSB = 0;
  localparam int CFG_DUMMY_LSB = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  localparam int SUSP_ERASE_BIT = 2;
  localparam int SUSP_PROG_BIT = 3;
  localparam int PAGE_BYTES = 256;
  localparam int FIFO_DEPTH = 8;
  localparam int BLOCKS = 16;

  typedef enum logic [2:0] {
    ST_OPC = 3'b000,
    ST_ADDR = 3'b001,
    ST_DATA = 3'b010,
    ST_CFG = 3'b011,
    ST_STAT = 3'b100,
    ST_SKIP = 3'b101
  } cmd_state_type;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_PROG = 2'b01,
    OP_ERASE = 2'b10,
    OP_CHIP = 2'b11
  } op_type;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] io;
  } pins_type;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] data;
  } wr_type;

  typedef struct packed {
    logic complement;
    logic top_bottom;
    logic [2:0] level;
  } protect_type;
endpackage : flash_pkg

// *** host_model.sv ***
// host controller model: select, serial clock and io drive for the flash pins
// assumes the bench merges io_o with the device's enables into io_w_i
`timescale 1ns/1ps

module host_model (
  // pins towards the device
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] io_o,
  // merged io wires
  input wire logic [3:0] io_w_i
);
  localparam real HALF = 62.5;

  // parked: deselected, clock still and low, hold/protect lines high
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io_o = 4'hc;
  end

  // one frame, bytes msb first; bytes from quad_from on go as two nibbles;
  // stray single bits before deselect give an off-boundary end on purpose
  task automatic frame(input logic [7:0] b[$], input int quad_from, input int stray,
                       output logic [7:0] rx);
    int n;
    rx = 8'h00;
    #0.25; // keeps link edges off the core clock edges
    cs_n_o = 1'b0;
    #HALF;
    for (int k = 0; k < b.size() + 1; k++) begin
      n = (k == b.size()) ? stray : (k >= quad_from) ? 2 : 8;
      for (int i = 0; i < n; i++) begin
        if (k < b.size() && n == 2) io_o = (i == 0) ? b[k][7:4] : b[k][3:0];
        else io_o = {2'b11, ~io_o[1], (k < b.size()) ? b[k][7-i] : 1'b1};
        #HALF sclk_o = 1'b1;
        rx = {rx[6:0], io_w_i[1]};
        #HALF sclk_o = 1'b0;
      end
    end
    #HALF;
    cs_n_o = 1'b1;
    io_o = ~io_o; // released lines must not keep the last value
    #40;
  endtask : frame
endmodule : host_model

// *** testbench.sv ***
// self-checking bench for the flash program/suspend block
// assumes the host model shifts frames; array writes are gathered here
`timescale 1ns/1ps

module testbench;
  import flash_pkg::*;
  localparam int SC = 20;
  localparam int EC = 2000;
  logic clk_i, reset_n_i, cs_n, sclk, four_wire, pin_dis, e_start, e_chip, ready, stall;
  logic busy, write_enable_latch, esusp, psusp, wr_valid;
  logic [3:0] host_io, dut_io, dut_oe, io_w;
  logic [1:0] drive, dummy;
  logic [7:0] rx, s, cfg;
  logic [23:0] a;
  logic [7:0] q[$];
  logic [31:0] wq[$];
  protect_type prot;
  wr_type wr;
  int n_mismatch, total_checks, waited;

  // device drive wins where enabled, the host model elsewhere
  assign io_w = (dut_oe & dut_io) | (~dut_oe & host_io);

  flash_program_suspend #(.PROG_CYCLES(50), .ERASE_CYCLES(EC), .SUSPEND_CYCLES(SC)) DUT (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n), .sclk_i(sclk), .io_i(io_w),
    .io_o(dut_io), .io_oe_o(dut_oe), .four_wire_command_mode_i(four_wire),
    .pin_function_disable_bit_i(pin_dis), .protect_i(prot), .erase_start_i(e_start),
    .erase_is_chip_i(e_chip), .write_busy_flag_o(busy), .write_enable_latch_o(write_enable_latch),
    .erase_suspended_flag_o(esusp), .program_suspended_flag_o(psusp),
    .drive_strength_o(drive), .read_dummy_o(dummy), .mem_wr_valid_o(wr_valid),
    .mem_wr_o(wr), .mem_wr_ready_i(ready));

  host_model host (.cs_n_o(cs_n), .sclk_o(sclk), .io_o(host_io), .io_w_i(io_w));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // array side: random back-pressure, full stall to fill the fifo
  always @(negedge clk_i) ready <= stall ? 1'b0 : ($urandom_range(3) != 0);
  always @(posedge clk_i) if (wr_valid && ready) wq.push_back(wr);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  function automatic int qf();
    return four_wire ? 0 : 99;
  endfunction : qf

  // data index that ends up in column c, or -1 when the column is untouched
  function automatic int kept_index(input int col, input int n, input int c);
    int i0;
    i0 = (n > 256) ? n - 256 : 0;
    kept_index = i0 + ((c - col - i0) % 256 + 256) % 256;
    if (kept_index >= n) kept_index = -1;
  endfunction : kept_index

  task automatic send(input logic [7:0] b[$], input int quad_from, input int stray);
    @(negedge clk_i);
    host.frame(b, quad_from, stray, rx);
  endtask : send

  task automatic status(input logic [7:0] opc);
    send('{opc, 8'h00}, 99, 0);
    s = rx;
  endtask : status

  task automatic fill(input int n);
    q.delete();
    a = {4'h0, 12'($urandom), 8'($urandom)};
    repeat (n) q.push_back(8'($urandom));
  endtask : fill

  task automatic page_write(input logic [7:0] opc, input int stray);
    logic [7:0] b[$];
    b = '{opc, a[23:16], a[15:8], a[7:0]};
    b = {b, q};
    send('{OPC_WRITE_ENABLE_CMD}, qf(), 0);
    check(write_enable_latch, 1'b1);
    send(b, (opc == OPC_QPROG) ? 4 : qf(), stray);
  endtask : page_write

  // bounded wait for the busy flag to drop; waited gives the cycles spent
  task automatic wait_idle;
    for (waited = 0; waited < 30000; waited++) begin
      @(negedge clk_i);
      if (busy === 1'b0) return;
    end
    check(busy, 1'b0);
  endtask : wait_idle

  task automatic check_prog;
    int k, i;
    k = 0;
    for (int c = 0; c < 256; c++) begin
      i = kept_index(a[7:0], q.size(), c);
      if (i >= 0) begin
        check(k < wq.size() ? wq[k] : 32'hx, {a[23:8], c[7:0], q[i]});
        k++;
      end
    end
    check(wq.size(), k);
    wq.delete();
  endtask : check_prog

  task automatic pulse_erase(input logic chip);
    e_chip = chip;
    e_start = 1'b1;
    @(negedge clk_i);
    e_start = 1'b0;
    repeat (5) @(negedge clk_i);
  endtask : pulse_erase

  task automatic do_reset;
    reset_n_i = 1'b0;
    repeat (5) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (5) @(negedge clk_i);
    check({drive, dummy, busy, write_enable_latch, esusp, psusp}, 8'h00);
  endtask : do_reset

  initial begin
    void'($urandom(32'h9064fe1e));
    reset_n_i = 1'b0;
    four_wire = 1'b0;
    pin_dis = 1'b0;
    e_start = 1'b0;
    e_chip = 1'b0;
    prot = '0;
    stall = 1'b0;
    do_reset();
    // config byte in single-line and four-wire command modes
    for (int m = 0; m < 2; m++) begin
      four_wire = m[0];
      cfg = 8'($urandom);
      send('{OPC_CFG, cfg}, qf(), 0);
      check({dummy, drive}, cfg[3:0]);
    end
    four_wire = 1'b0;
    // program without write enable is refused
    send('{OPC_PROG, 8'h00, 8'h00, 8'h00, 8'h55}, 99, 0);
    check({busy, 8'(wq.size())}, 9'h000);
    // random short programs near the page end, wrapping
    repeat (3) begin
      fill(1 + $urandom_range(11));
      a[7:0] = 8'hf8 | 8'($urandom_range(7));
      page_write(OPC_PROG, 0);
      check(busy, 1'b1);
      wait_idle();
      check(write_enable_latch, 1'b0);
      check_prog();
    end
    // off-boundary deselect cancels
    fill(2);
    page_write(OPC_PROG, 3);
    repeat (30) @(negedge clk_i);
    check({busy, 8'(wq.size())}, 9'h000);
    // fully protected array
    prot.level = 3'h5;
    page_write(OPC_PROG, 0);
    wait_idle();
    check(wq.size(), 0);
    prot = '0;
    // quad program: refused without the pin bit, then accepted
    fill(5);
    page_write(OPC_QPROG, 0);
    repeat (30) @(negedge clk_i);
    check({busy, 8'(wq.size())}, 9'h000);
    pin_dis = 1'b1;
    page_write(OPC_QPROG, 0);
    wait_idle();
    check_prog();
    // four-wire program of 300 bytes keeps the last 256
    four_wire = 1'b1;
    fill(300);
    page_write(OPC_PROG, 0);
    wait_idle();
    check_prog();
    four_wire = 1'b0;
    // suspend is ignored during chip erase
    pulse_erase(1'b1);
    send('{OPC_SUSPEND}, 99, 0);
    check({esusp, psusp}, 2'b00);
    wait_idle();
    // program suspend with the fifo held full, status reads, resume
    stall = 1'b1;
    fill(20);
    page_write(OPC_PROG, 0);
    status(OPC_STATUS);
    check(s[1:0], 2'b01);
    send('{OPC_SUSPEND}, 99, 0);
    repeat (SC + 5) @(negedge clk_i);
    check({busy, esusp, psusp}, 3'b001);
    status(OPC_SUSP_STATUS);
    check(s[3:0], 4'b1000);
    send('{OPC_SUSPEND}, 99, 0);
    check({esusp, psusp}, 2'b01);
    send('{OPC_RESUME}, 99, 0);
    check({busy, psusp}, 2'b10);
    stall = 1'b0;
    wait_idle();
    check_prog();
    do_reset();
    // erase suspend, chip erase refused meanwhile, resume within budget
    pulse_erase(1'b0);
    send('{OPC_SUSPEND}, 99, 0);
    repeat (SC + 5) @(negedge clk_i);
    check({busy, esusp, psusp}, 3'b010);
    pulse_erase(1'b1);
    check({busy, esusp}, 2'b01);
    send('{OPC_RESUME}, 99, 0);
    check({busy, esusp}, 2'b10);
    wait_idle();
    check(waited <= EC - 240, 1'b1);
    complete_run();
  end

  // watchdog sized to about twice the expected run
  initial begin
    #400000;
    n_mismatch++;
    $display("MISMATCH %0t watchdog expired", $time);
    complete_run();
  end
endmodule : testbench
